// ===== rtl/coef_preload.sv
`timescale 1ns/100ps
`include "fir_cfg.svh"
module coef_preload
(
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire fir_pkg::coef_grp_t       coef_grp_i,
  input  wire logic                     load_en_i,
  input  wire logic                     hold_en_i,
  output fir_pkg::coef_grp_t [3:0]      hold_o
);
  fir_pkg::coef_grp_t load_reg [0:`FIR_STG-1];
  fir_pkg::coef_grp_t hold_reg [0:`FIR_STG-1];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int s = 0; s < `FIR_STG; s++)
      begin
        load_reg[s] <= '0;
        hold_reg[s] <= '0;
      end
    end
    else
    begin
      if (load_en_i)
      begin
        load_reg[0] <= coef_grp_i;
        for (int s = 1; s < `FIR_STG; s++)
          load_reg[s] <= load_reg[s-1];
      end
      if (hold_en_i)
      begin
        for (int s = 0; s < `FIR_STG; s++)
          hold_reg[s] <= load_reg[s];
      end
    end
  end

  always_comb
  begin
    for (int s = 0; s < `FIR_STG; s++)
      hold_o[s] = hold_reg[s];
  end

  coef_freeze_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !hold_en_i |=> hold_reg[0] == $past(hold_reg[0]) && hold_reg[3] == $past(hold_reg[3]))
    else $error("active coefficients moved while frozen");
  coef_cascade_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_en_i [*4] |=> load_reg[3] == $past(coef_grp_i, 4))
    else $error("preload did not reach last stage in four clocks");
  coef_swap_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    !hold_en_i ##1 load_en_i [*4] ##[1:2] hold_en_i);
endmodule

// ===== rtl/fir_cfg.svh
`ifndef FIR_CFG_SVH
`define FIR_CFG_SVH
`define FIR_DW 16
`define FIR_CW 16
`define FIR_AW 40
`define FIR_TAPS 16
`define FIR_STG 4
`define FIR_PHASES 4
`define FIR_CH_NUM 15
`define FIR_CHW 4
`define FIR_FIFO_DEPTH 16
`define FIR_DEC_M 0
`define FIR_DRAIN_CYC 5
`define FIR_JOBS_PAR 3
`define FIR_JOBS_SER 15
`endif

// ===== rtl/fir_pkg.sv
`include "fir_cfg.svh"
package fir_pkg;
  typedef enum logic [1:0] {MODE_INTERP, MODE_DECIM, MODE_SINGLE} mode_t;
  typedef logic [3:0][`FIR_CW-1:0] coef_grp_t;
  typedef struct packed {
    logic [`FIR_CHW-1:0] chan;
    logic [`FIR_DW-1:0]  data;
  } sample_t;
  typedef struct packed {
    logic                valid;
    logic                first;
    logic                last;
    logic [1:0]          grp;
    logic [`FIR_CHW-1:0] chan;
    logic [3:0]          sel;
  } job_t;
endpackage

// ===== rtl/polyphase_fir_filter.sv
`timescale 1ns/100ps
`include "fir_cfg.svh"
module polyphase_fir_filter
(
  input  wire logic                                 mclk_i,
  input  wire logic                                 resetn_i,
  input  wire fir_pkg::mode_t                       mode_i,
  input  wire logic                                 single_mac_i,
  input  wire logic [`FIR_CHW-1:0]                  chan_last_i,
  input  wire logic                                 in_frame_i,
  input  wire logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0]  in_samples_i,
  output logic                                      in_ready_o,
  input  wire fir_pkg::coef_grp_t                   coef_grp_i,
  input  wire logic                                 coef_load_en_i,
  input  wire logic                                 coef_hold_en_i,
  output logic                                      out_valid_o,
  output logic [`FIR_AW-1:0]                        out_data_o,
  output logic [`FIR_CHW-1:0]                       out_chan_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} state_t;

  logic                                rst_meta_reg;
  logic                                rst_n;
  logic                                busy_reg;
  logic                                in_ready_reg;
  logic [`FIR_CHW-1:0]                 idx_reg;
  logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0] cap_reg;
  logic                                take;
  logic                                mux_last;
  logic                                mux_adv;
  logic                                busy_next;
  fir_pkg::sample_t                    mux_smp;
  logic                                fifo_in_ready;
  logic                                fifo_out_valid;
  logic                                fifo_out_ready;
  fir_pkg::sample_t                    fifo_smp;
  fir_pkg::coef_grp_t [3:0]            coef_hold;
  logic [`FIR_DW-1:0]  line_mem  [0:`FIR_CH_NUM-1][0:`FIR_TAPS-1];
  logic [1:0]          phase_mem [0:`FIR_CH_NUM-1];
  state_t                              state_reg;
  fir_pkg::mode_t                      run_mode_reg;
  logic                                run_single_reg;
  logic [`FIR_CHW-1:0]                 run_chan_reg;
  logic [3:0]                          q_reg;
  logic [2:0]                          drain_reg;
  logic                                pop;
  logic                                trig;
  logic [3:0]                          q_last;
  logic                                is_interp;
  logic [1:0]                          job_grp;
  logic [1:0]                          job_sub;
  fir_pkg::job_t                       job0;
  fir_pkg::job_t                       in_job    [0:`FIR_STG-1];
  fir_pkg::job_t                       pipe_reg  [0:`FIR_STG-1];
  logic signed [`FIR_AW-1:0]           psum_next [0:`FIR_STG-1];
  logic signed [`FIR_AW-1:0]           psum_reg  [0:`FIR_STG-1];
  logic signed [`FIR_AW-1:0]           acc_reg;
  logic signed [`FIR_AW-1:0]           acc_sum;
  fir_pkg::job_t                       fin_job;
  logic                                out_valid_reg;
  logic [`FIR_AW-1:0]                  out_data_reg;
  logic [`FIR_CHW-1:0]                 out_chan_reg;
  logic [2:0]                          out_cnt_reg;
  logic                                had_pop_reg;

  // tap index: {grp,stage} for sample and coefficient, sample {0,stage} and coefficient {stage,grp} when interpolating
  function automatic logic [3:0] tap_idx(input logic interp, input logic coef,
                                         input logic [1:0] grp, input logic [1:0] stg);
    tap_idx = (interp && coef) ? {stg, grp} : (interp ? {2'h0, stg} : {grp, stg});
  endfunction

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'h0;
      rst_n        <= 1'h0;
    end
    else
    begin
      rst_meta_reg <= 1'h1;
      rst_n        <= rst_meta_reg;
    end
  end

  // interleaving multiplexer: a frame holds one sample per channel
  assign take      = in_frame_i && in_ready_reg;
  assign mux_last  = (idx_reg == chan_last_i) || (idx_reg == 4'(`FIR_CH_NUM - 1));
  assign mux_adv   = busy_reg && fifo_in_ready;
  assign busy_next = take ? 1'h1 : ((mux_adv && mux_last) ? 1'h0 : busy_reg);
  assign mux_smp   = '{chan: idx_reg, data: cap_reg[idx_reg]};
  assign in_ready_o = in_ready_reg;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg     <= 1'h0;
      in_ready_reg <= 1'h0;
      idx_reg      <= '0;
      cap_reg      <= '0;
    end
    else
    begin
      busy_reg     <= busy_next;
      in_ready_reg <= !busy_next;
      if (take)
      begin
        cap_reg <= in_samples_i;
        idx_reg <= '0;
      end
      else if (mux_adv)
        idx_reg <= 4'(idx_reg + 1'h1);
    end
  end

  mux_order_a: assert property (
    mux_adv && !mux_last |=> mux_smp.chan == $past(mux_smp.chan) + 4'h1)
    else $error("interleaver skipped a channel");

  sample_fifo #(
    .W     ($bits(fir_pkg::sample_t)),
    .DEPTH (`FIR_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (busy_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mux_smp),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_smp)
  );

  coef_preload u_coef (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n),
    .coef_grp_i (coef_grp_i),
    .load_en_i  (coef_load_en_i),
    .hold_en_i  (coef_hold_en_i),
    .hold_o     (coef_hold)
  );

  // the engine takes a sample only when idle, so the delay line is stable while jobs read it
  assign fifo_out_ready = (state_reg == ST_IDLE);
  assign pop            = fifo_out_ready && fifo_out_valid;
  // one run per fourth decimator input
  assign trig   = (mode_i != fir_pkg::MODE_DECIM) || (phase_mem[fifo_smp.chan] == 2'h3);
  assign q_last = run_single_reg ? 4'(`FIR_JOBS_SER) : 4'(`FIR_JOBS_PAR);
  assign is_interp = (run_mode_reg == fir_pkg::MODE_INTERP);
  // serial mode walks one stage per job
  assign job_grp = run_single_reg ? q_reg[3:2] : q_reg[1:0];
  assign job_sub = run_single_reg ? q_reg[1:0] : 2'h0;

  always_comb
  begin
    job0       = '0;
    job0.valid = (state_reg == ST_RUN);
    job0.grp   = job_grp;
    job0.chan  = run_chan_reg;
    job0.sel   = run_single_reg ? (4'h1 << job_sub) : 4'hF;
    if (is_interp)
    begin
      job0.first = (job_sub == 2'h0);
      job0.last  = !run_single_reg || (job_sub == 2'h3);
    end
    else
    begin
      job0.first = (q_reg == 4'h0);
      job0.last  = (q_reg == q_last);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= ST_IDLE;
      run_mode_reg   <= fir_pkg::MODE_INTERP;
      run_single_reg <= 1'h0;
      run_chan_reg   <= '0;
      q_reg          <= '0;
      drain_reg      <= '0;
      for (int c = 0; c < `FIR_CH_NUM; c++)
      begin
        phase_mem[c] <= '0;
        for (int i = 0; i < `FIR_TAPS; i++)
          line_mem[c][i] <= '0;
      end
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (pop)
          begin
            line_mem[fifo_smp.chan][0] <= fifo_smp.data;
            for (int i = 1; i < `FIR_TAPS; i++)
              line_mem[fifo_smp.chan][i] <= line_mem[fifo_smp.chan][i-1];
            phase_mem[fifo_smp.chan] <= 2'(phase_mem[fifo_smp.chan] + 1'h1);
            run_mode_reg   <= mode_i;
            run_single_reg <= single_mac_i;
            run_chan_reg   <= fifo_smp.chan;
            q_reg          <= '0;
            if (trig)
              state_reg <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          q_reg <= 4'(q_reg + 1'h1);
          if (q_reg == q_last)
          begin
            state_reg <= ST_DRAIN;
            drain_reg <= '0;
          end
        end
        default:
        begin
          drain_reg <= 3'(drain_reg + 1'h1);
          if (drain_reg == 3'(`FIR_DRAIN_CYC - 1))
            state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign in_job[0] = job0;
  for (genvar s = 1; s < `FIR_STG; s++)
  begin : g_skew
    assign in_job[s] = pipe_reg[s-1];
  end

  for (genvar s = 0; s < `FIR_STG; s++)
  begin : g_mac
    logic [3:0]                  xi;
    logic [3:0]                  ci;
    logic signed [2*`FIR_DW-1:0] prod;
    logic signed [`FIR_AW-1:0]   base;
    assign xi   = tap_idx(is_interp, 1'h0, in_job[s].grp, 2'(s));
    assign ci   = tap_idx(is_interp, 1'h1, in_job[s].grp, 2'(s));
    assign prod = $signed(line_mem[in_job[s].chan][xi]) * $signed(coef_hold[ci[3:2]][ci[1:0]]);
    if (s == 0)
    begin : g_first
      assign base = '0;
    end
    else
    begin : g_rest
      assign base = psum_reg[s-1];
    end
    assign psum_next[s] = base + (in_job[s].sel[s] ? `FIR_AW'(prod) : '0);
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int s = 0; s < `FIR_STG; s++)
      begin
        pipe_reg[s] <= '0;
        psum_reg[s] <= '0;
      end
    end
    else
    begin
      for (int s = 0; s < `FIR_STG; s++)
      begin
        pipe_reg[s] <= in_job[s];
        psum_reg[s] <= psum_next[s];
      end
    end
  end

  assign fin_job = pipe_reg[`FIR_STG-1];
  assign acc_sum = fin_job.first ? psum_reg[`FIR_STG-1] : acc_reg + psum_reg[`FIR_STG-1];

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg       <= '0;
      out_valid_reg <= 1'h0;
      out_data_reg  <= '0;
      out_chan_reg  <= '0;
    end
    else
    begin
      out_valid_reg <= fin_job.valid && fin_job.last;
      if (fin_job.valid)
        acc_reg <= acc_sum;
      if (fin_job.valid && fin_job.last)
      begin
        out_data_reg <= acc_sum;
        out_chan_reg <= fin_job.chan;
      end
    end
  end

  assign out_valid_o = out_valid_reg;
  assign out_data_o  = out_data_reg;
  assign out_chan_o  = out_chan_reg;

  // helper: outputs seen since the last accepted sample
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_cnt_reg <= '0;
      had_pop_reg <= 1'h0;
    end
    else
    begin
      had_pop_reg <= had_pop_reg || pop;
      out_cnt_reg <= pop ? '0 : 3'(out_cnt_reg + out_valid_reg);
    end
  end

  interp_four_a: assert property (
    pop && had_pop_reg && is_interp && (state_reg == ST_IDLE) |-> out_cnt_reg == 3'h4)
    else $error("interpolator did not give four outputs per input");
  decim_phase_a: assert property (
    pop && mode_i == fir_pkg::MODE_DECIM |=> (state_reg == ST_RUN) == ($past(phase_mem[fifo_smp.chan]) == 2'h3))
    else $error("decimator started on the wrong input");
  coef_turn_a: assert property (
    state_reg == ST_RUN && !run_single_reg && q_reg != q_last |=> job0.grp == 2'($past(job0.grp) + 1'h1))
    else $error("coefficient groups not cycled in turn");
  single_mac_a: assert property (
    job0.valid && run_single_reg |-> $onehot(job0.sel))
    else $error("more than one stage active in single mode");
  stage_skew_a: assert property (
    1'h1 |=> pipe_reg[1] == $past(pipe_reg[0], `FIR_DEC_M + 1) && pipe_reg[3] == $past(pipe_reg[0], 3))
    else $error("stage operands not skewed by one cycle");
  acc_reload_a: assert property (
    fin_job.valid && fin_job.first |=> acc_reg == $past(psum_reg[`FIR_STG-1]))
    else $error("accumulator kept a previous output");
  final_acc_a: assert property (
    out_valid_reg |-> $past(fin_job.valid && fin_job.last) && $past(pipe_reg[0].valid, 4))
    else $error("output without a closing partial sum");
  chan_order_a: assert property (
    out_valid_reg |-> out_chan_reg == run_chan_reg)
    else $error("output channel differs from the channel in work");
  decim_taps_a: assert property (
    job0.valid && !is_interp && !run_single_reg |-> ##5 out_valid_reg == $past(job0.last, 5))
    else $error("decimated output not closed after sixteen taps");

  interp_out_c: cover property (out_valid_reg && is_interp);
  decim_out_c: cover property (out_valid_reg && run_mode_reg == fir_pkg::MODE_DECIM);
  multi_chan_c: cover property (out_valid_reg && out_chan_reg != '0);
endmodule

// ===== rtl/sample_fifo.sv
`timescale 1ns/100ps
module sample_fifo
#(
  parameter int W     = 20,
  parameter int DEPTH = 16
)
(
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [0:DEPTH-1];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_reg != CW'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_reg] <= in_data_i;
        wr_reg      <= AW'(wr_reg + 1'h1);
      end
      if (pop)
        rd_reg <= AW'(rd_reg + 1'h1);
      cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pop));
    end
  end

  fifo_full_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cnt_reg == CW'(DEPTH) && in_valid_i && !out_ready_i |=>
      cnt_reg == CW'(DEPTH) && $stable(wr_reg))
    else $error("fifo accepts while full");
  fifo_fill_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    cnt_reg == CW'(DEPTH));
endmodule

// ===== verification/stream_partner.sv
`timescale 1ns/100ps
`include "fir_cfg.svh"
module stream_partner
(
  input  wire logic                               mclk_i,
  input  wire logic                               in_ready_i,
  output logic                                    in_frame_o,
  output logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0]     samples_o,
  input  wire logic                               out_valid_i,
  input  wire logic [`FIR_AW-1:0]                 out_data_i,
  input  wire logic [`FIR_CHW-1:0]                out_chan_i
);
  logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0] pend_q[$];
  logic [`FIR_CHW+`FIR_AW-1:0]         got_q[$];
  initial
  begin
    in_frame_o = 1'b0;
    samples_o  = '0;
  end
  always @(posedge mclk_i)
  begin
    if (in_frame_o === 1'b1 && in_ready_i === 1'b1)
      void'(pend_q.pop_front());
    if (pend_q.size() != 0)
    begin
      in_frame_o <= 1'b1;
      samples_o  <= pend_q[0];
    end
    else
    begin
      // idle lines toggle so stale data is never mistaken for a frame
      in_frame_o <= 1'b0;
      samples_o  <= ~samples_o;
    end
  end
  // consumer has no back-pressure: every pulse is taken
  always @(posedge mclk_i)
    if (out_valid_i === 1'b1)
      got_q.push_back({out_chan_i, out_data_i});
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`include "fir_cfg.svh"
module tb_top;
  typedef struct {fir_pkg::mode_t md; logic sm; int chl; int nfr; int nout;} row_t;
  logic                                mclk_i;
  logic                                resetn_i;
  fir_pkg::mode_t                      mode_i;
  logic                                single_mac_i;
  logic [`FIR_CHW-1:0]                 chan_last_i;
  logic                                in_frame_i;
  logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0] in_samples_i;
  logic                                in_ready_o;
  fir_pkg::coef_grp_t                  coef_grp_i;
  logic                                coef_load_en_i;
  logic                                coef_hold_en_i;
  logic                                out_valid_o;
  logic [`FIR_AW-1:0]                  out_data_o;
  logic [`FIR_CHW-1:0]                 out_chan_o;
  int                                  num_errors = 0;
  int                                  n_tests = 0;
  int                                  nsmp = 0;
  int                                  h[16];
  int                                  xh[`FIR_CH_NUM][16];
  int                                  dcnt[`FIR_CH_NUM];
  logic [`FIR_CHW+`FIR_AW-1:0]         exp_q[$];
  row_t rows[6] = '{'{fir_pkg::MODE_DECIM, 1'b0, 2, 8, 6},
                    '{fir_pkg::MODE_DECIM, 1'b1, 0, 4, 1},
                    '{fir_pkg::MODE_INTERP, 1'b0, 0, 3, 12},
                    '{fir_pkg::MODE_INTERP, 1'b1, 1, 2, 16},
                    '{fir_pkg::MODE_SINGLE, 1'b0, 14, 2, 30},
                    '{fir_pkg::MODE_SINGLE, 1'b1, 3, 2, 8}};

  polyphase_fir_filter dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .mode_i(mode_i),
    .single_mac_i(single_mac_i), .chan_last_i(chan_last_i), .in_frame_i(in_frame_i),
    .in_samples_i(in_samples_i), .in_ready_o(in_ready_o), .coef_grp_i(coef_grp_i),
    .coef_load_en_i(coef_load_en_i), .coef_hold_en_i(coef_hold_en_i),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_chan_o(out_chan_o));
  stream_partner src_u (.mclk_i(mclk_i), .in_ready_i(in_ready_o), .in_frame_o(in_frame_i),
    .samples_o(in_samples_i), .out_valid_i(out_valid_o), .out_data_i(out_data_o),
    .out_chan_i(out_chan_o));

  initial mclk_i = 1'b0;
  always #10 mclk_i = ~mclk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic check_word(input logic [`FIR_CHW+`FIR_AW-1:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic check_num(input int got, input int exp, input string msg);
    n_tests++;
    if (got != exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic int coef(input int s, input int i);
    return (s == 0) ? ((i % 3 == 0) ? -(i + 1) : (i + 1)) : (2 * i - 9);
  endfunction
  function automatic logic [`FIR_CHW+`FIR_AW-1:0] mac(input int c, b, st, n);
    longint s;
    s = 0;
    for (int j = 0; j < n; j++)
      s += longint'(h[b + st * j]) * xh[c][j];
    return {4'(c), 40'(s)};
  endfunction

  task automatic do_reset(input int n);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    src_u.pend_q.delete();
    tick(n);
    #1;
    check_bit(in_ready_o, 1'b0, "ready in reset");
    check_bit(out_valid_o, 1'b0, "valid in reset");
    check_word(44'(out_data_o), 44'h0, "data in reset");
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    tick(2);
    #1;
    check_bit(in_ready_o, 1'b0, "ready early");
    @(posedge mclk_i);
    #1;
    check_bit(in_ready_o, 1'b1, "ready late");
    h = '{default: 0};
    xh = '{default: '{default: 0}};
    dcnt = '{default: 0};
    exp_q.delete();
    src_u.got_q.delete();
  endtask
  task automatic set_mode(input fir_pkg::mode_t md, input logic sm, input int chl);
    @(posedge mclk_i);
    mode_i <= md;
    single_mac_i <= sm;
    chan_last_i <= 4'(chl);
    @(posedge mclk_i);
  endtask
  // holding frozen, new set preloaded behind it
  task automatic preload(input int s);
    for (int g = 3; g >= 0; g--)
    begin
      @(posedge mclk_i);
      coef_load_en_i <= 1'b1;
      coef_hold_en_i <= 1'b0;
      for (int e = 0; e < 4; e++)
        coef_grp_i[e] <= 16'(coef(s, 4 * g + e));
    end
    @(posedge mclk_i);
    coef_load_en_i <= 1'b0;
    coef_grp_i <= '1;
  endtask
  // apply once the ripple is done
  task automatic apply_coefs(input int s);
    @(posedge mclk_i);
    coef_hold_en_i <= 1'b1;
    @(posedge mclk_i);
    coef_hold_en_i <= 1'b0;
    for (int i = 0; i < 16; i++)
      h[i] = coef(s, i);
  endtask
  task automatic send_frame(input int chl);
    logic [`FIR_CH_NUM-1:0][`FIR_DW-1:0] fr;
    fr = '1;
    for (int c = 0; c <= chl; c++)
    begin
      nsmp++;
      fr[c] = 16'(nsmp * 37 % 500 - 250);
      for (int j = 15; j > 0; j--)
        xh[c][j] = xh[c][j - 1];
      xh[c][0] = int'($signed(fr[c]));
      if (mode_i == fir_pkg::MODE_INTERP)
        for (int k = 0; k < 4; k++)
          exp_q.push_back(mac(c, k, 4, 4));
      else if (mode_i == fir_pkg::MODE_SINGLE || dcnt[c] % 4 == 3)
        exp_q.push_back(mac(c, 0, 1, 16));
      if (mode_i == fir_pkg::MODE_DECIM)
        dcnt[c]++;
    end
    @(negedge mclk_i);
    src_u.pend_q.push_back(fr);
  endtask
  task automatic drain(input int n);
    int w;
    w = 0;
    while (src_u.got_q.size() < n && w < 4000)
    begin
      @(posedge mclk_i);
      w++;
    end
    tick(30);
    check_num(src_u.got_q.size(), n, "output count");
    while (src_u.got_q.size() != 0 && exp_q.size() != 0)
      check_word(src_u.got_q.pop_front(), exp_q.pop_front(), "result");
    exp_q.delete();
    src_u.got_q.delete();
  endtask

  initial
  begin
    resetn_i = 1'b0;
    mode_i = fir_pkg::MODE_INTERP;
    single_mac_i = 1'b0;
    chan_last_i = '0;
    coef_grp_i = '0;
    coef_load_en_i = 1'b0;
    coef_hold_en_i = 1'b0;
    do_reset(16);
    preload(0);
    apply_coefs(0);
    foreach (rows[i])
    begin
      set_mode(rows[i].md, rows[i].sm, rows[i].chl);
      for (int f = 0; f < rows[i].nfr; f++)
        send_frame(rows[i].chl);
      drain(rows[i].nout);
    end
    // preload runs while the engine still uses the old set
    set_mode(fir_pkg::MODE_SINGLE, 1'b0, 0);
    send_frame(0);
    preload(1);
    drain(1);
    apply_coefs(1);
    send_frame(0);
    send_frame(0);
    drain(2);
    // reset while a full interleaved frame is in flight
    set_mode(fir_pkg::MODE_SINGLE, 1'b1, 14);
    send_frame(14);
    tick(40);
    do_reset(2);
    set_mode(fir_pkg::MODE_SINGLE, 1'b0, 0);
    send_frame(0);
    drain(1);
    finish_test;
  end

  initial
  begin
    tick(20000);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test;
  end
endmodule
